// ===== hw/trf_map.svh
// trigger readout formatter: offsets, field positions, reset values and timing counts
`ifndef TRF_MAP_SVH
`define TRF_MAP_SVH
`define TRF_CMD_TRIG 3'h4
`define TRF_CMD_CAL 3'h7
`define TRF_CMD_RESYNC 3'h6
`define TRF_CMD_BC0 3'h5
`define TRF_ALIGN_ZEROS 3
`define TRF_CLK_PERIOD_PS 4000
`define TRF_CAL_PULSE_NS 1000
`define TRF_CAL_CYCLES ((`TRF_CAL_PULSE_NS * 1000 + `TRF_CLK_PERIOD_PS - 1) / `TRF_CLK_PERIOD_PS)
`define TRF_PFX_BCN 4'ha
`define TRF_PFX_EVT 4'hc
`define TRF_PFX_ID 4'he
`define TRF_CRC_POLY 16'h1021
`define TRF_CRC_BAD 16'hffff
`define TRF_CRC_BITS 16
`define TRF_PKT_BITS 192
`define TRF_UPSET_MAX 8'hff
`define TRF_LAT_RST 8'h7f
`define TRF_CHIP_ID 12'ha5c
`define TRF_REG_LATENCY 8'h00
`define TRF_REG_CTRL 8'h04
`define TRF_REG_UPSET 8'h08
`define TRF_REG_STATUS 8'h0c
`define TRF_CTRL_TEST_BIT 0
`define TRF_TEST_MSG 176'h5245_4144_4f55_5420_4c49_4e4b_2054_4553_5420_574f_5244
`endif

// ===== hw/trf_pkg.sv
// trigger readout formatter: shared types
package trf_pkg;
   typedef struct packed {
      logic trig;
      logic cal;
      logic resync;
      logic bc0;
   } trf_cmd_type;
   typedef enum logic [1:0] {FMT_IDLE, FMT_FETCH, FMT_SHIFT, FMT_GAP} trf_fmt_type;
   typedef struct packed {
      trf_fmt_type fsm;
      logic [7:0] bit_cnt;
      logic [7:0] latency;
      logic test_mode;
   } trf_ctl_type;
   typedef struct packed {
      logic aligned;
      logic [1:0] zeros;
      logic [1:0] phase;
      logic shift;
   } trf_dec_ctl_type;
   typedef struct packed {
      logic [11:0] crossing_number;
      logic [7:0] evt;
      logic [127:0] hits;
   } trf_event_type;
endpackage

// ===== hw/trf_secded.sv
// trigger readout formatter: hamming single-correct double-detect coder
`timescale 1ns/1ps
module trf_secded #(
   parameter int DATA_W = 148,
   parameter int PAR_W = 8
) (
   input logic [DATA_W-1:0] enc_data,
   output logic [DATA_W+PAR_W:0] enc_word,
   input logic [DATA_W+PAR_W:0] dec_word,
   output logic [DATA_W-1:0] dec_data,
   output logic single_err,
   output logic double_err
);
   localparam int N = DATA_W + PAR_W;
   logic [N:1] enc_cw;
   logic [N:1] dec_cw;
   logic [PAR_W-1:0] syn;
   logic ovr;

   // parity bits sit at power-of-two positions, data fills the rest
   always_comb begin
      int j;
      j = 0;
      enc_cw = '0;
      for (int p = 1; p <= N; p++) begin
         if ((p & (p - 1)) != 0) begin
            enc_cw[p] = enc_data[j];
            j++;
         end
      end
      for (int b = 0; b < PAR_W; b++) begin
         for (int p = 1; p <= N; p++) begin
            if (p[b] && ((p & (p - 1)) != 0)) begin
               enc_cw[1 << b] = enc_cw[1 << b] ^ enc_cw[p];
            end
         end
      end
      enc_word = {^enc_cw, enc_cw};
   end

   // syndrome names the bad position; overall parity splits single from double
   always_comb begin
      int j;
      j = 0;
      dec_cw = dec_word[N-1:0];
      syn = '0;
      dec_data = '0;
      for (int b = 0; b < PAR_W; b++) begin
         for (int p = 1; p <= N; p++) begin
            if (p[b]) begin
               syn[b] = syn[b] ^ dec_cw[p];
            end
         end
      end
      ovr = ^dec_word;
      single_err = ovr && (int'(syn) <= N);
      double_err = (!ovr && syn != '0) || (ovr && int'(syn) > N);
      if (ovr && syn != '0 && int'(syn) <= N) begin
         dec_cw[int'(syn)] = ~dec_cw[int'(syn)];
      end
      for (int p = 1; p <= N; p++) begin
         if ((p & (p - 1)) != 0) begin
            dec_data[j] = dec_cw[p];
            j++;
         end
      end
   end
endmodule

// ===== hw/trf_cmd_decoder.sv
// trigger readout formatter: serial fast command decoder, triplicated
`timescale 1ns/1ps
`include "trf_map.svh"
module trf_cmd_decoder (
   input logic clk,
   input logic sys_rst,
   input logic fast_command_line,
   output trf_pkg::trf_cmd_type cmd,
   output logic upset
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      trf_pkg::trf_dec_ctl_type [2:0] ctl;
      trf_pkg::trf_cmd_type cmd;
      logic upset;
   } trf_dec_state_type;
   trf_dec_state_type st_reg;
   trf_dec_state_type st_next;
   trf_pkg::trf_dec_ctl_type v;
   trf_pkg::trf_dec_ctl_type n;
   logic line;

   // majority vote, then all three copies reload from the voted next state
   always_comb begin
      st_next = st_reg;
      st_next.sync1 = fast_command_line;
      st_next.sync2 = st_reg.sync1;
      line = st_reg.sync2;
      v = trf_pkg::trf_dec_ctl_type'((st_reg.ctl[0] & st_reg.ctl[1]) | (st_reg.ctl[0] & st_reg.ctl[2]) |
                                    (st_reg.ctl[1] & st_reg.ctl[2]));
      n = v;
      st_next.cmd = '0;
      if (!v.aligned) begin
         // a one while unaligned could be the middle of a word, so it is dropped
         if (line) begin
            n.zeros = 2'h0;
         end else if (v.zeros == 2'(`TRF_ALIGN_ZEROS - 1)) begin
            n.aligned = 1'b1;
            n.zeros = 2'h0;
         end else begin
            n.zeros = v.zeros + 2'h1;
         end
      end else if (v.phase == 2'h0) begin
         if (line) begin
            n.phase = 2'h1;
         end
      end else if (v.phase == 2'h1) begin
         n.shift = line;
         n.phase = 2'h2;
      end else begin
         n.phase = 2'h0;
         case ({1'b1, v.shift, line})
            `TRF_CMD_TRIG: begin
               st_next.cmd.trig = 1'b1;
            end
            `TRF_CMD_CAL: begin
               st_next.cmd.cal = 1'b1;
            end
            `TRF_CMD_RESYNC: begin
               st_next.cmd.resync = 1'b1;
            end
            `TRF_CMD_BC0: begin
               st_next.cmd.bc0 = 1'b1;
            end
            default: begin
               n.aligned = 1'b0;
            end
         endcase
      end
      st_next.ctl = {n, n, n};
      st_next.upset = (st_reg.ctl[0] != v) || (st_reg.ctl[1] != v) || (st_reg.ctl[2] != v);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cmd = st_reg.cmd;
   assign upset = st_reg.upset;

   property p_dec_align;
      @(posedge clk) disable iff (sys_rst) (!st_reg.sync2)[*3] |=> v.aligned;
   endproperty
   a_dec_align: assert property (p_dec_align) else $error("decoder did not align after three lows");

   property p_dec_trig;
      @(posedge clk) disable iff (sys_rst)
         (v.aligned && v.phase == 2'h2 && !v.shift && !st_reg.sync2) |=> (cmd.trig && !cmd.cal && !cmd.bc0);
   endproperty
   a_dec_trig: assert property (p_dec_trig) else $error("code 100 not decoded as trigger");
endmodule

// ===== hw/trf_formatter.sv
// trigger readout formatter: pipeline, trigger buffer and packet serialiser
`timescale 1ns/1ps
`include "trf_map.svh"
module trf_formatter #(
   parameter int CH = 128,
   parameter int PIPE_DEPTH = 256,
   parameter int PIPE_W = 144,
   parameter int TB_DEPTH = 128,
   parameter int TB_W = 180,
   parameter int AF_LEVEL = 120,
   parameter logic [11:0] CHIP_ID = `TRF_CHIP_ID // arbitrary value
) (
   input logic clk,
   input logic sys_rst,
   input logic fast_command_line,
   input logic [CH-1:0] channel_hits,
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic calibration_pulse,
   output logic serial_packet_out,
   output logic serial_valid
);
   localparam int PA = $clog2(PIPE_DEPTH);
   localparam int TA = $clog2(TB_DEPTH);
   localparam int PAR_W = 8;
   localparam int DATA_W = $bits(trf_pkg::trf_event_type);
   localparam int CODE_W = DATA_W + PAR_W + 1;
   localparam int PAY_W = `TRF_PKT_BITS - `TRF_CRC_BITS;
   localparam trf_pkg::trf_ctl_type CTL_RST = '{fsm: trf_pkg::FMT_IDLE, bit_cnt: 8'h00,
                                                latency: `TRF_LAT_RST, test_mode: 1'b0};

   typedef struct packed {
      logic [CH-1:0] hit_s1;
      logic [CH-1:0] hit_s2;
      trf_pkg::trf_ctl_type [2:0] ctl;
      logic [11:0] bc;
      logic [7:0] ec;
      logic [7:0] cal_cnt;
      logic cal_out;
      logic [8:0] wait_cnt;
      logic [PA-1:0] pipe_ptr;
      logic trig_q;
      logic [11:0] trig_bcn;
      logic [7:0] trig_evt;
      logic [TA-1:0] wp;
      logic [TA-1:0] rp;
      logic [TA:0] cnt;
      logic [`TRF_PKT_BITS-1:0] sr;
      logic [7:0] upset;
      logic [31:0] rdata;
   } trf_state_type;

   trf_state_type st_reg;
   trf_state_type st_next;
   trf_pkg::trf_ctl_type v;
   trf_pkg::trf_ctl_type c;
   trf_pkg::trf_cmd_type cmd;
   trf_pkg::trf_event_type ev_in;
   trf_pkg::trf_event_type ev_out;
   logic dec_upset;
   logic mism;
   logic push;
   logic pop;
   logic flag_empty;
   logic flag_af;
   logic flag_full;
   logic [3:0] flags;
   logic [PAY_W-1:0] payload;
   logic [PA-1:0] pipe_rd_idx;
   logic [CODE_W-1:0] enc_word;
   logic [DATA_W-1:0] dec_data;
   logic dbl_err;
   logic [PIPE_W-1:0] pipe_mem [PIPE_DEPTH];
   logic [PIPE_W-1:0] pipe_q;
   logic [TB_W-1:0] tb_mem [TB_DEPTH];
   logic [TB_W-1:0] tb_q;

   // remainder of the zero-extended payload, taken one 16-bit word per step
   function automatic logic [15:0] crc_calc(input logic [PAY_W-1:0] d);
      logic [15:0] r;
      r = 16'h0000;
      for (int w = PAY_W / 16 - 1; w >= 0; w--) begin
         for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[w * 16 + i]) ? `TRF_CRC_POLY : 16'h0000);
         end
      end
      return r;
   endfunction

   trf_cmd_decoder u_dec (
      .clk(clk),
      .sys_rst(sys_rst),
      .fast_command_line(fast_command_line),
      .cmd(cmd),
      .upset(dec_upset)
   );

   trf_secded #(.DATA_W(DATA_W), .PAR_W(PAR_W)) u_ham (
      .enc_data(ev_in),
      .enc_word(enc_word),
      .dec_word(tb_q[CODE_W-1:0]),
      .dec_data(dec_data),
      .single_err(),
      .double_err(dbl_err)
   );

   // memories: pipeline written every clock, read at the latency offset
   always_ff @(posedge clk) begin
      pipe_mem[st_reg.pipe_ptr] <= PIPE_W'(st_reg.hit_s2);
      pipe_q <= pipe_mem[pipe_rd_idx];
      if (push) begin
         tb_mem[st_reg.wp] <= TB_W'(enc_word);
      end
      if (pop) begin
         tb_q <= tb_mem[st_reg.rp];
      end
   end

   assign ev_in = '{crossing_number: st_reg.trig_bcn, evt: st_reg.trig_evt, hits: pipe_q[CH-1:0]};
   assign ev_out = trf_pkg::trf_event_type'(dec_data);
   assign flag_empty = st_reg.cnt == '0;
   assign flag_af = st_reg.cnt >= (TA + 1)'(AF_LEVEL);
   assign flag_full = st_reg.cnt == (TA + 1)'(TB_DEPTH);
   assign flags = {dbl_err, flag_empty, flag_af, flag_full};
   assign payload = v.test_mode ? `TRF_TEST_MSG :
                    {`TRF_PFX_BCN, ev_out.crossing_number, `TRF_PFX_EVT, ev_out.evt, flags,
                     `TRF_PFX_ID, CHIP_ID, ev_out.hits};

   // one pass over the whole state; control copies all load the voted result
   always_comb begin
      st_next = st_reg;
      v = trf_pkg::trf_ctl_type'((st_reg.ctl[0] & st_reg.ctl[1]) | (st_reg.ctl[0] & st_reg.ctl[2]) |
                                (st_reg.ctl[1] & st_reg.ctl[2]));
      c = v;
      mism = (st_reg.ctl[0] != v) || (st_reg.ctl[1] != v) || (st_reg.ctl[2] != v);
      push = 1'b0;
      pop = 1'b0;
      pipe_rd_idx = st_reg.pipe_ptr - PA'(v.latency) - PA'(1);
      st_next.hit_s1 = channel_hits;
      st_next.hit_s2 = st_reg.hit_s1;
      st_next.pipe_ptr = st_reg.pipe_ptr + PA'(1);
      st_next.bc = st_reg.bc + 12'h001;
      if ((mism || dec_upset) && st_reg.upset != `TRF_UPSET_MAX) begin
         st_next.upset = st_reg.upset + 8'h01;
      end
      // register port: writes steer the block, reads answer one cycle later
      if (reg_wr) begin
         case (reg_addr)
            `TRF_REG_LATENCY: begin
               c.latency = reg_wdata[7:0];
            end
            `TRF_REG_CTRL: begin
               c.test_mode = reg_wdata[`TRF_CTRL_TEST_BIT];
            end
            default: begin
            end
         endcase
      end
      st_next.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `TRF_REG_LATENCY: begin
               st_next.rdata = {24'h000000, v.latency};
            end
            `TRF_REG_CTRL: begin
               st_next.rdata = {31'h0000_0000, v.test_mode};
            end
            `TRF_REG_UPSET: begin
               st_next.rdata = {24'h000000, st_reg.upset};
            end
            `TRF_REG_STATUS: begin
               st_next.rdata = {21'h000000, flag_full, flag_af, flag_empty, 8'(st_reg.cnt)};
            end
            default: begin
            end
         endcase
      end
      // calibration pulse: a repeat request while it runs is ignored
      if (st_reg.cal_cnt != 8'h00) begin
         st_next.cal_cnt = st_reg.cal_cnt - 8'h01;
      end else if (cmd.cal) begin
         st_next.cal_cnt = 8'(`TRF_CAL_CYCLES);
      end
      st_next.cal_out = st_next.cal_cnt != 8'h00;
      // trigger: count always, copy column only once the pipeline holds valid data
      st_next.trig_q = 1'b0;
      if (st_reg.wait_cnt != 9'h000) begin
         st_next.wait_cnt = st_reg.wait_cnt - 9'h001;
      end
      if (cmd.trig) begin
         st_next.ec = st_reg.ec + 8'h01;
         if (st_reg.wait_cnt == 9'h000) begin
            st_next.trig_q = 1'b1;
            st_next.trig_bcn = st_reg.bc;
            st_next.trig_evt = st_reg.ec;
         end
      end
      // a full buffer drops the event rather than stall the pipeline
      if (st_reg.trig_q && !flag_full) begin
         push = 1'b1;
         st_next.wp = st_reg.wp + TA'(1);
      end
      case (v.fsm)
         trf_pkg::FMT_IDLE, trf_pkg::FMT_GAP: begin
            if (v.test_mode || (!flag_empty && st_reg.wait_cnt == 9'h000)) begin
               pop = !v.test_mode;
               c.fsm = trf_pkg::FMT_FETCH;
            end else begin
               c.fsm = trf_pkg::FMT_IDLE;
            end
         end
         trf_pkg::FMT_FETCH: begin
            st_next.sr = {payload, (dbl_err && !v.test_mode) ? `TRF_CRC_BAD : crc_calc(payload)};
            c.bit_cnt = 8'(`TRF_PKT_BITS - 1);
            c.fsm = trf_pkg::FMT_SHIFT;
         end
         trf_pkg::FMT_SHIFT: begin
            st_next.sr = {st_reg.sr[`TRF_PKT_BITS-2:0], 1'b0};
            if (v.bit_cnt == 8'h00) begin
               c.fsm = trf_pkg::FMT_GAP;
            end else begin
               c.bit_cnt = v.bit_cnt - 8'h01;
            end
         end
         default: begin
            c.fsm = trf_pkg::FMT_IDLE;
         end
      endcase
      if (pop) begin
         st_next.rp = st_reg.rp + TA'(1);
      end
      st_next.cnt = st_reg.cnt + (TA + 1)'(push) - (TA + 1)'(pop);
      if (cmd.bc0) begin
         st_next.ec = 8'h00;
         st_next.bc = 12'h000;
      end
      if (cmd.resync) begin
         c.fsm = trf_pkg::FMT_IDLE;
         c.bit_cnt = 8'h00;
         st_next.ec = 8'h00;
         st_next.bc = 12'h000;
         st_next.cal_cnt = 8'h00;
         st_next.cal_out = 1'b0;
         st_next.trig_q = 1'b0;
         st_next.wp = '0;
         st_next.rp = '0;
         st_next.cnt = '0;
         st_next.sr = '0;
         st_next.wait_cnt = {1'b0, c.latency} + 9'h001;
         push = 1'b0;
         pop = 1'b0;
      end
      st_next.ctl = {c, c, c};
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.ctl <= {CTL_RST, CTL_RST, CTL_RST};
         st_reg.wait_cnt <= {1'b0, `TRF_LAT_RST} + 9'h001;
      end else begin
         st_reg <= st_next;
      end
   end

   // link side changes on the falling edge, giving the serializer half a period of setup
   always_ff @(negedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_valid <= 1'b0;
         serial_packet_out <= 1'b0;
      end else begin
         serial_valid <= v.fsm == trf_pkg::FMT_SHIFT;
         serial_packet_out <= (v.fsm == trf_pkg::FMT_SHIFT) && st_reg.sr[`TRF_PKT_BITS-1];
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign calibration_pulse = st_reg.cal_out;

   // helper: length of the current run of valid bits; a resync cuts a packet one edge late
   logic [8:0] run_len;
   logic resync_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_len <= 9'h000;
         resync_q <= 1'b0;
      end else begin
         run_len <= serial_valid ? run_len + 9'h001 : 9'h000;
         resync_q <= cmd.resync;
      end
   end

   property p_cal_len;
      @(posedge clk) disable iff (sys_rst || cmd.resync)
         $rose(calibration_pulse) |-> ##249 calibration_pulse ##1 !calibration_pulse;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("calibration pulse not 250 cycles");

   property p_ec_inc;
      @(posedge clk) disable iff (sys_rst) (cmd.trig && !cmd.resync) |=> st_reg.ec == $past(st_reg.ec) + 8'h01;
   endproperty
   a_ec_inc: assert property (p_ec_inc) else $error("event counter did not advance on trigger");

   property p_bc0;
      @(posedge clk) disable iff (sys_rst) cmd.bc0 |=> (st_reg.ec == 8'h00 && st_reg.bc == 12'h000);
   endproperty
   a_bc0: assert property (p_bc0) else $error("crossing zero did not clear counters");

   property p_resync;
      @(posedge clk) disable iff (sys_rst)
         cmd.resync |=> (st_reg.cnt == '0 && v.fsm == trf_pkg::FMT_IDLE && st_reg.wait_cnt == {1'b0, v.latency} + 9'h001);
   endproperty
   a_resync: assert property (p_resync) else $error("resync left state behind");

   property p_quiet;
      @(posedge clk) disable iff (sys_rst) (v.fsm != trf_pkg::FMT_SHIFT) |-> (!serial_valid && !serial_packet_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("serial output active outside a packet");

   property p_gap;
      @(posedge clk) disable iff (sys_rst)
         (v.fsm == trf_pkg::FMT_SHIFT && v.bit_cnt == 8'h00 && !cmd.resync) |=> (!serial_valid)[*2];
   endproperty
   a_gap: assert property (p_gap) else $error("idle gap shorter than two cycles");

   property p_pkt_len;
      @(posedge clk) disable iff (sys_rst || cmd.resync || resync_q) $fell(serial_valid) |-> run_len == 9'd192;
   endproperty
   a_pkt_len: assert property (p_pkt_len) else $error("packet not 192 bits long");

   property p_header;
      @(posedge clk) disable iff (sys_rst)
         (v.fsm == trf_pkg::FMT_FETCH && !v.test_mode && !cmd.resync) |=>
         (st_reg.sr[191:188] == 4'ha && st_reg.sr[175:172] == 4'hc && st_reg.sr[159:156] == 4'he);
   endproperty
   a_header: assert property (p_header) else $error("header prefixes wrong");

   property p_bad_crc;
      @(posedge clk) disable iff (sys_rst)
         (v.fsm == trf_pkg::FMT_FETCH && dbl_err && !v.test_mode && !cmd.resync) |=> st_reg.sr[15:0] == 16'hffff;
   endproperty
   a_bad_crc: assert property (p_bad_crc) else $error("double error packet lacks all-ones crc");

   property p_upset;
      @(posedge clk) disable iff (sys_rst)
         (mism && st_reg.upset != 8'hff) |=> st_reg.upset == $past(st_reg.upset) + 8'h01;
   endproperty
   a_upset: assert property (p_upset) else $error("upset counter missed a disagreement");

   property p_heal;
      @(posedge clk) disable iff (sys_rst) mism |=> (st_reg.ctl[0] == st_reg.ctl[1] && st_reg.ctl[1] == st_reg.ctl[2]);
   endproperty
   a_heal: assert property (p_heal) else $error("control copies did not reconverge");

   c_packet: cover property (@(posedge clk) disable iff (sys_rst) $fell(serial_valid));
   c_test: cover property (@(posedge clk) disable iff (sys_rst) v.test_mode && v.fsm == trf_pkg::FMT_SHIFT);
   c_full: cover property (@(posedge clk) disable iff (sys_rst) flag_full && st_reg.trig_q);
   c_double: cover property (@(posedge clk) disable iff (sys_rst) v.fsm == trf_pkg::FMT_FETCH && dbl_err);
endmodule

// ===== tb/trf_rx_model.sv
// link receiver model: gathers serial packets and checks their crc
`timescale 1ns/1ps
module trf_rx_model (
   input wire logic clk,
   input wire logic serial_packet_out,
   input wire logic serial_valid,
   output logic [191:0] pkt,
   output logic crc_ok,
   output int pkt_cnt,
   output int gap
);
   logic [191:0] sh_reg = '0;
   int n_reg = 0;
   int low_reg = 0;
   // remainder of data plus crc by the generator, bit by bit
   function automatic logic crc_zero(logic [191:0] d);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 191; i >= 0; i--) begin
         r = {r[14:0], d[i]} ^ (r[15] ? 16'h1021 : 16'h0000);
      end
      return r == 16'h0000;
   endfunction
   initial pkt_cnt = 0;
   // sample at rising edge, bits launched on falling edge are settled here
   always @(posedge clk) begin
      if (serial_valid === 1'b1) begin
         if (n_reg == 0) gap <= low_reg;
         low_reg <= 0;
         sh_reg <= {sh_reg[190:0], serial_packet_out};
         n_reg <= (n_reg == 191) ? 0 : n_reg + 1;
         if (n_reg == 191) begin
            pkt <= {sh_reg[190:0], serial_packet_out};
            crc_ok <= crc_zero({sh_reg[190:0], serial_packet_out});
            pkt_cnt <= pkt_cnt + 1;
         end
      end else begin
         low_reg <= low_reg + 1;
      end
   end
endmodule

// ===== tb/trf_formatter_tb.sv
// self-checking bench for the trigger readout formatter
`timescale 1ns/1ps
`include "trf_map.svh"
module trf_formatter_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fast_command_line = 1'b0;
   logic [127:0] channel_hits = {16{8'h5a}};
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic calibration_pulse;
   logic serial_packet_out;
   logic serial_valid;
   logic [191:0] pkt;
   logic crc_ok;
   logic [31:0] d;
   logic [11:0] bcn1;
   int pkt_cnt, gap, k, error_cnt = 0, n_tests = 0, cyc = 0;
   // reset values of the map, plus one unmapped place
   logic [31:0] rows [5][2] = '{'{32'h00, 32'h7f}, '{32'h04, 32'h0}, '{32'h08, 32'h0},
      '{32'h0c, 32'h100}, '{32'h40, 32'h0}};
   trf_formatter trf_formatter_inst (.clk(clk), .sys_rst(sys_rst), .fast_command_line(fast_command_line),
      .channel_hits(channel_hits), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .calibration_pulse(calibration_pulse),
      .serial_packet_out(serial_packet_out), .serial_valid(serial_valid));
   trf_rx_model trf_rx_model_inst (.clk(clk), .serial_packet_out(serial_packet_out),
      .serial_valid(serial_valid), .pkt(pkt), .crc_ok(crc_ok), .pkt_cnt(pkt_cnt), .gap(gap));
   always #2 clk = ~clk;
   task automatic chk(string nm, logic [191:0] seen, logic [191:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // read data is taken at the edge closing the answer cycle
   task automatic rd(logic [7:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic cmd(logic [2:0] c);
      for (int i = 2; i >= 0; i--) begin
         fast_command_line <= c[i];
         @(posedge clk);
      end
   endtask
   task automatic waitpk(int n);
      fast_command_line <= 1'b0;
      for (k = 0; k < 3000 && pkt_cnt < n; k++) @(posedge clk);
      chk("packet count", pkt_cnt, n);
      chk("crc", crc_ok, 1'b1);
   endtask
   // hang guard, far above the roughly 1400 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (140) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         rd(rows[i][0][7:0], d);
         chk("register", d, rows[i][1]);
      end
      $display("register test done");
      // two triggers back to back: fifo order, numbering, gap
      cmd(3'h4);
      cmd(3'h4);
      waitpk(1);
      bcn1 = pkt[187:176];
      chk("header one", {pkt[191:188], pkt[175:164], pkt[159:144]}, {8'hac, 8'h00, 16'hea5c});
      chk("hits", pkt[143:16], channel_hits);
      waitpk(2);
      chk("header two", pkt[191:144], {4'ha, bcn1 + 12'h003, 32'hc014ea5c});
      chk("hits two", pkt[143:16], channel_hits);
      chk("gap", gap, 2);
      $display("trigger test done");
      cmd(3'h5);
      cmd(3'h4);
      waitpk(3);
      chk("event after zero", pkt[171:164], 8'h00);
      cmd(3'h7);
      fast_command_line <= 1'b0;
      for (k = 0; k < 20 && calibration_pulse !== 1'b1; k++) @(posedge clk);
      for (k = 0; k < 400 && calibration_pulse === 1'b1; k++) @(posedge clk);
      chk("cal pulse", k, `TRF_CAL_CYCLES);
      $display("zero and calibration test done");
      wr(8'h04, 32'h1);
      waitpk(pkt_cnt + 2);
      chk("test message", pkt[191:16], `TRF_TEST_MSG);
      wr(8'h04, 32'h0);
      cmd(3'h4);
      cmd(3'h6);
      fast_command_line <= 1'b0;
      repeat (5) @(posedge clk);
      rd(8'h0c, d);
      chk("status after resync", d, 32'h100);
      $display("test mode and resync test done");
      stop_test();
   end
endmodule
